// file: include/zbsp_params.svh
// constants of the zero-turnaround burst memory port
`ifndef ZBSP_PARAMS_SVH
`define ZBSP_PARAMS_SVH

// ==========================================================
// geometry
`define ZBSP_ADDR_W      17
`define ZBSP_DATA_W      36
`define ZBSP_LANES       4
`define ZBSP_LANE_W      9
`define ZBSP_MEM_WORDS   131072

// ==========================================================
// burst and write queue
`define ZBSP_BURST_LO_W  2
`define ZBSP_FIFO_DEPTH  8
`define ZBSP_CNT_RESET   2'h0

`endif

// file: include/zbsp_pkg.sv
// types shared by the memory port and its write queue
package zbsp_pkg;
    `include "zbsp_params.svh"

    typedef logic [`ZBSP_ADDR_W-1:0] zbsp_addr_t;
    typedef logic [`ZBSP_DATA_W-1:0] zbsp_word_t;
    typedef logic [`ZBSP_LANES-1:0]  zbsp_strobe_t;

    // write waiting for its data word
    typedef struct packed {
        zbsp_addr_t   addr;
        zbsp_strobe_t strobes_n;
    } zbsp_wentry_s;

    localparam int ZBSP_WENTRY_W = $bits(zbsp_wentry_s);

    typedef struct packed {
        zbsp_addr_t                  addr;
        logic [`ZBSP_BURST_LO_W-1:0] base_lo;
        logic [`ZBSP_BURST_LO_W-1:0] cnt;
        logic                        burst_on;
        logic                        burst_wr;
        logic                        drive;
        zbsp_word_t                  dq;
    } zbsp_state_s;
endpackage : zbsp_pkg

// file: rtl/zbsp_fifo.sv
// first-word-fall-through queue with valid and ready on both sides
`timescale 1ns/1ps
module zbsp_fifo #(
    parameter int WIDTH = 21,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,       // device clock
    input  wire logic             reset_n,   // async reset, active low
    input  wire logic             in_valid,  // entry offered
    output      logic             in_ready,  // room for an entry
    input  wire logic [WIDTH-1:0] in_data,   // entry to store
    output      logic             out_valid, // head entry present
    input  wire logic             out_ready, // head taken this edge
    output      logic [WIDTH-1:0] out_data   // head entry
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0]   count;
    } zbsp_fifo_state_s;

    zbsp_fifo_state_s st;
    zbsp_fifo_state_s next_st;
    logic [WIDTH-1:0] store [0:DEPTH-1];
    logic             push;
    logic             pop;

    assign in_ready  = (st.count != FULL_CNT);
    assign out_valid = (st.count != '0);
    assign out_data  = store[st.rp];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always_comb begin
        next_st = st;
        if (push) begin
            next_st.wp = st.wp + 1'b1;
        end
        if (pop) begin
            next_st.rp = st.rp + 1'b1;
        end
        if (push && !pop) begin
            next_st.count = st.count + 1'b1;
        end else if (pop && !push) begin
            next_st.count = st.count - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            store[st.wp] <= in_data;
        end
    end
endmodule : zbsp_fifo

// file: rtl/zbsp_port.sv
// zero-turnaround flow-through burst memory port with its word array
`timescale 1ns/1ps
`include "zbsp_params.svh"
module zbsp_port
    import zbsp_pkg::*;
(
    input  wire logic         clk,                    // device clock, 125 MHz
    input  wire logic         reset_n,                // async reset, active low
    input  wire zbsp_addr_t   addr_in,                // word address
    input  wire logic         advance_not_load,       // high advance, low load
    input  wire logic         read_not_write,         // high read, low write
    input  wire logic         chip_select_low_a_n,    // chip select, active low
    input  wire logic         chip_select_pair_b_n,   // chip select, active low
    input  wire logic         chip_select_pair_b_high, // chip select, active high
    input  wire logic         clock_gate_n,           // high suspends the port
    input  wire logic         burst_order_select,     // high interleaved, low linear
    input  wire zbsp_strobe_t byte_write_strobes_n,   // lane write strobes, low
    input  wire logic         output_gate_n,          // high floats the bus
    input  wire zbsp_word_t   data_in,                // bus level in
    output      zbsp_word_t   data_out,               // bus drive value
    output      logic         data_oe,                // bus driven, high
    output      logic         burst_active            // burst sequence running
);
    // ==========================================================
    // helpers
    function automatic logic [`ZBSP_BURST_LO_W-1:0] burst_lo(
        input logic [`ZBSP_BURST_LO_W-1:0] base,
        input logic [`ZBSP_BURST_LO_W-1:0] cnt,
        input logic                        interleave
    );
        logic [`ZBSP_BURST_LO_W-1:0] r;
        r = interleave ? (base ^ cnt) : (base + cnt);
        return r;
    endfunction : burst_lo

    function automatic zbsp_word_t merge_lanes(
        input zbsp_word_t   old_word,
        input zbsp_word_t   new_word,
        input zbsp_strobe_t strobes_n
    );
        zbsp_word_t r;
        r = old_word;
        for (int i = 0; i < `ZBSP_LANES; i++) begin
            if (!strobes_n[i]) begin
                r[i*`ZBSP_LANE_W +: `ZBSP_LANE_W] = new_word[i*`ZBSP_LANE_W +: `ZBSP_LANE_W];
            end
        end
        return r;
    endfunction : merge_lanes

    // ==========================================================
    // state
    zbsp_state_s  st;
    zbsp_state_s  next_st;
    zbsp_word_t   mem [0:`ZBSP_MEM_WORDS-1];

    logic         selected;
    logic         running;
    logic         load;
    logic         advance;
    zbsp_addr_t   cont_addr;
    zbsp_addr_t   rd_addr;
    zbsp_word_t   rd_word;
    logic         push_valid;
    logic         push_ready;
    zbsp_wentry_s push_entry;
    logic         head_valid;
    zbsp_wentry_s head;
    logic [ZBSP_WENTRY_W-1:0] head_bits;
    logic         commit;

    assign selected  = !chip_select_low_a_n && !chip_select_pair_b_n
                       && chip_select_pair_b_high;
    assign running   = clock_gate_n == 1'b0;
    assign load      = running && selected && !advance_not_load;
    assign advance   = running && selected && advance_not_load && st.burst_on;
    assign cont_addr = {st.addr[`ZBSP_ADDR_W-1:`ZBSP_BURST_LO_W],
                        burst_lo(st.base_lo, st.cnt + 1'b1, burst_order_select)};
    assign rd_addr   = load ? addr_in : cont_addr;
    assign head      = zbsp_wentry_s'(head_bits);
    assign commit    = head_valid && running;

    // a write retiring on this edge to the word being read is forwarded
    always_comb begin
        rd_word = mem[rd_addr];
        if (commit && head.addr == rd_addr) begin
            rd_word = merge_lanes(rd_word, data_in, head.strobes_n);
        end
    end

    // ==========================================================
    // write queue: address and strobes wait for next cycle's data
    always_comb begin
        push_entry.addr      = rd_addr;
        push_entry.strobes_n = byte_write_strobes_n;
        push_valid = (load && !read_not_write)
                     || (advance && st.burst_wr);
    end

    zbsp_fifo #(
        .WIDTH (ZBSP_WENTRY_W),
        .DEPTH (`ZBSP_FIFO_DEPTH)
    ) u_wq (
        .clk       (clk),
        .reset_n   (reset_n),
        .in_valid  (push_valid),
        .in_ready  (push_ready),
        .in_data   (push_entry),
        .out_valid (head_valid),
        .out_ready (running),
        .out_data  (head_bits)
    );

    always_ff @(posedge clk) begin
        if (commit) begin
            mem[head.addr] <= merge_lanes(mem[head.addr], data_in, head.strobes_n);
        end
    end

    // ==========================================================
    // sequencing
    always_comb begin
        next_st = st;
        if (!running) begin
            next_st = st;
        end else if (!selected) begin
            next_st.burst_on = 1'b0;
            next_st.drive    = 1'b0;
        end else if (!advance_not_load) begin
            next_st.addr     = addr_in;
            next_st.base_lo  = addr_in[`ZBSP_BURST_LO_W-1:0];
            next_st.cnt      = `ZBSP_CNT_RESET;
            next_st.burst_wr = !read_not_write;
            next_st.burst_on = read_not_write || push_ready;
            next_st.drive    = read_not_write;
            next_st.dq       = read_not_write ? rd_word : st.dq;
        end else if (st.burst_on) begin
            next_st.addr  = cont_addr;
            next_st.cnt   = st.cnt + 1'b1;
            next_st.drive = !st.burst_wr;
            next_st.dq    = st.burst_wr ? st.dq : rd_word;
            if (st.burst_wr && !push_ready) begin
                next_st.burst_on = 1'b0;
            end
        end else begin
            next_st.drive = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign data_out     = st.dq;
    assign data_oe      = st.drive && !output_gate_n;
    assign burst_active = st.burst_on;

    // ==========================================================
    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    a_burst_high_bits: assert property (advance |=>
        st.addr[`ZBSP_ADDR_W-1:`ZBSP_BURST_LO_W]
        == $past(st.addr[`ZBSP_ADDR_W-1:`ZBSP_BURST_LO_W]))
        else $error("burst changed upper address bits");
    a_load_address: assert property (load |=> st.addr == $past(addr_in)
        && st.cnt == `ZBSP_CNT_RESET)
        else $error("load did not take the new address");
    a_burst_dir_hold: assert property (advance |=> st.burst_wr == $past(st.burst_wr))
        else $error("burst direction changed while advancing");
    a_write_float: assert property (load && !read_not_write |=> !st.drive)
        else $error("write load drove the bus");
    a_strobe_pairing: assert property (push_valid && push_ready |=> head_valid)
        else $error("write entry not queued for next data");
    a_deselect_stop: assert property (running && !selected |=> !st.burst_on
        && $stable(st.addr))
        else $error("deselect did not stop the burst");
    a_deselect_float: assert property (running && !selected |=> !data_oe)
        else $error("bus still driven after deselect");
    a_pending_done: assert property (running && !selected && head_valid
        |=> !head_valid)
        else $error("pending write not completed on deselect");
    a_select_polar: assert property (running && !chip_select_pair_b_high |=> !st.drive)
        else $error("high select ignored");
    a_read_drive: assert property (load && read_not_write && !output_gate_n
        ##1 !output_gate_n |-> data_oe && data_out == $past(rd_word))
        else $error("read word not driven next cycle");
    a_gate_hold: assert property (!running |=> st == $past(st))
        else $error("state moved while clock gated");
    a_out_gate: assert property (output_gate_n |-> !data_oe)
        else $error("bus driven with output gate high");

    // ==========================================================
    // burst counter and address order
    a_burst_step: assert property (advance |=>
        st.cnt == $past(st.cnt) + 2'h1)
        else $error("burst counter did not step by one");
    a_linear_order: assert property (advance && !burst_order_select |=>
        st.addr[1:0] == $past(2'(st.base_lo + st.cnt + 2'h1)))
        else $error("linear burst order wrong");
    a_inter_order: assert property (advance && burst_order_select |=>
        st.addr[1:0] == $past(st.base_lo ^ 2'(st.cnt + 2'h1)))
        else $error("interleaved burst order wrong");

    // ==========================================================
    // load, direction and write queue
    a_load_dir: assert property (load |=>
        st.burst_wr == !$past(read_not_write))
        else $error("burst direction not taken at load");
    a_load_starts: assert property (load |=> st.burst_on)
        else $error("load did not start a burst");
    a_write_queued: assert property (load && !read_not_write |-> push_valid)
        else $error("write load not queued");
    a_read_no_push: assert property (load && read_not_write |-> !push_valid)
        else $error("read load queued a write");
    a_wr_burst_float: assert property (advance && st.burst_wr |=> !st.drive)
        else $error("write burst drove the bus");
    a_deselect_no_op: assert property (running && !selected |-> !push_valid)
        else $error("deselect started a write");

    // ==========================================================
    // clock gate and output gate
    a_gate_queue: assert property (!running |=> $stable(head_valid))
        else $error("write queue moved while clock gated");
    a_gate_no_write: assert property (!running |-> !commit)
        else $error("memory written while clock gated");
    a_oe_source: assert property (data_oe |-> st.drive)
        else $error("bus driven without a read");

    c_read_burst: cover property (load && read_not_write ##1 advance [*3]);
    c_write_burst: cover property (load && !read_not_write ##1 advance [*3]);
    c_turnaround: cover property (load && !read_not_write ##1 load && read_not_write);
    c_gated_write: cover property (load && !read_not_write ##1 !running ##1 commit);
    c_read_deselect: cover property (load && read_not_write ##1 running && !selected);
endmodule : zbsp_port

// file: sim/zbsp_host.sv
// host controller model driving the memory port pins
`timescale 1ns/1ps
module zbsp_host
    import zbsp_pkg::*;
(
    input  wire logic         clk,    // device clock
    output      zbsp_addr_t   addr,   // word address
    output      logic         adv,    // high advance, low load
    output      logic         rnw,    // high read, low write
    output      logic [2:0]   cs,     // {low a, pair b low, pair b high}
    output      logic         gate_n, // high suspends the port
    output      logic         order,  // burst order select
    output      zbsp_strobe_t strb_n, // lane write strobes, low
    output      logic         og_n,   // output gate, high floats
    output      zbsp_word_t   bus     // host side of the data bus
);
    logic       drv_q = 1'b0;
    logic       wr_q  = 1'b0;
    zbsp_word_t dat   = '0;
    zbsp_word_t nxt   = '0;

    initial begin
        {addr, adv, rnw, cs, gate_n, order, strb_n, og_n} = '0;
    end

    // released bus shows the inverse of the last word
    assign bus = drv_q ? dat : ~dat;

    task automatic step(input logic [2:0] c, input logic a_d, r, input zbsp_addr_t a,
                        input zbsp_strobe_t s, input zbsp_word_t d, input logic wr, g);
        @(negedge clk);
        {cs, adv, rnw, addr, gate_n} = {c, a_d, r, a, g};
        strb_n = s;
        if (!g) begin
            drv_q = wr_q;
            if (wr_q) dat = nxt;
            wr_q = wr;
            nxt = d;
        end
    endtask : step
endmodule : zbsp_host

// file: sim/zbsp_port_test.sv
// self-checking bench for the memory port
`timescale 1ns/1ps
`include "zbsp_params.svh"
module zbsp_port_test;
    import zbsp_pkg::*;
    localparam logic [2:0] SEL = 3'h1;
    logic         clk = 1'b0;
    logic         reset_n = 1'b0;
    zbsp_addr_t   addr, r_addr = '0, p_a, ea = '0, rb;
    logic         adv, rnw, gate_n, order, og_n, data_oe, burst_active;
    logic [2:0]   cs;
    zbsp_strobe_t strb_n, p_s;
    zbsp_word_t   hbus, data_out, p_d, rd;
    logic         r_act = 0, r_wr = 0, r_oe = 0, p_v = 0;
    logic [1:0]   r_cnt = '0;
    int           bad_count = 0, num_checks = 0;
    zbsp_word_t   mem [zbsp_addr_t];

    initial begin
        forever #4 clk = ~clk;
    end

    zbsp_host host (.clk(clk), .addr(addr), .adv(adv), .rnw(rnw), .cs(cs), .gate_n(gate_n),
                    .order(order), .strb_n(strb_n), .og_n(og_n), .bus(hbus));

    zbsp_port dut (.clk(clk), .reset_n(reset_n), .addr_in(addr), .advance_not_load(adv),
        .read_not_write(rnw), .chip_select_low_a_n(cs[2]), .chip_select_pair_b_n(cs[1]),
        .chip_select_pair_b_high(cs[0]), .clock_gate_n(gate_n), .burst_order_select(order),
        .byte_write_strobes_n(strb_n), .output_gate_n(og_n),
        .data_in(data_oe ? data_out : hbus), .data_out(data_out), .data_oe(data_oe),
        .burst_active(burst_active));

    task automatic tally_and_finish;
        if (bad_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : tally_and_finish

    task automatic chk(input zbsp_word_t seen, exp, input string msg);
        num_checks++;
        if (seen !== exp) begin
            $display("[FAIL] %0t %s", $time, msg);
            bad_count++;
        end
    endtask : chk

    function automatic zbsp_word_t merge(input zbsp_word_t o, n, input zbsp_strobe_t s);
        for (int i = 0; i < `ZBSP_LANES; i++) begin
            if (!s[i]) o[i*`ZBSP_LANE_W +: `ZBSP_LANE_W] = n[i*`ZBSP_LANE_W +: `ZBSP_LANE_W];
        end
        return o;
    endfunction : merge

    // one host cycle, then the reference steps and the outputs are compared
    task automatic op(input logic [2:0] c, input logic a_d, r, input zbsp_addr_t a,
                      input zbsp_strobe_t s, input zbsp_word_t d, input logic g);
        logic sel;
        logic wr;
        sel = (c == SEL);
        wr = sel && (a_d ? (r_act && r_wr) : !r);
        host.step(c, a_d, r, a, s, d, wr, g);
        @(posedge clk);
        #1;
        if (!g) begin
            if (p_v) mem[p_a] = merge(mem.exists(p_a) ? mem[p_a] : 'x, p_d, p_s);
            if (!sel) r_act = 0;
            else if (!a_d) {r_addr, r_cnt, r_act, r_wr} = {a, 2'h0, 1'b1, !r};
            else if (r_act) r_cnt++;
            ea = {r_addr[16:2], order ? r_addr[1:0] ^ r_cnt : r_addr[1:0] + r_cnt};
            {p_v, p_a, p_s, p_d} = {wr, ea, s, d};
            r_oe = sel && r_act && !r_wr;
        end
        chk({35'h0, burst_active}, {35'h0, r_act}, "burst state");
        chk({35'h0, data_oe}, {35'h0, r_oe && !og_n}, "bus drive");
        if (r_oe && mem.exists(ea) && !$isunknown(mem[ea])) chk(data_out, mem[ea], "read");
    endtask : op

    function automatic zbsp_word_t rw();
        return zbsp_word_t'({$urandom, $urandom});
    endfunction : rw

    initial begin
        #200000;
        bad_count++;
        tally_and_finish;
    end

    initial begin
        void'($urandom(32'h305E));
        repeat (10) @(posedge clk);
        @(negedge clk);
        reset_n = 1'b1;
        rb = zbsp_addr_t'($urandom) & 17'h1FFF0;
        // ==========================================================
        // fill, bursts in both orders from every base, wrap on a fifth word
        for (int i = 0; i < 16; i++) op(SEL, 0, 0, rb + 17'(i), 4'h0, rw(), 0);
        for (int o = 0; o < 2; o++) begin
            for (int b = 0; b < 4; b++) begin
                host.order = 1'(o);
                op(SEL, 0, 1, rb + 17'(b + 4 * o), 4'h0, '0, 0);
                repeat (4) op(SEL, 1, 1'($urandom), rb, 4'($urandom), rw(), 0);
            end
        end
        // ==========================================================
        // partial writes with back-to-back reads, write bursts read back
        repeat (40) begin
            addr_pick: begin
                zbsp_addr_t a;
                a = rb + 17'($urandom % 16);
                op(SEL, 0, 0, a, 4'($urandom), rw(), 0);
                if ($urandom % 2) op(SEL, 0, 1, a, 4'h0, '0, 0);
            end
        end
        repeat (4) begin
            op(SEL, 0, 0, rb + 17'($urandom % 16), 4'($urandom), rw(), 0);
            repeat (3) op(SEL, 1, 1, rb, 4'($urandom), rw(), 0);
            op(SEL, 0, 1, r_addr, 4'h0, '0, 0);
            repeat (3) op(SEL, 1, 0, rb, 4'h0, '0, 0);
        end
        // ==========================================================
        // deselects by each select, write completing while deselected
        for (int k = 0; k < 3; k++) begin
            op(SEL, 0, 1, rb + 17'(k), 4'h0, '0, 0);
            op(SEL ^ (3'h1 << k), 1, 1, rb, 4'h0, '0, 0);
            op(SEL, 1, 1, rb, 4'h0, '0, 0);
        end
        op(SEL, 0, 0, rb + 17'h1, 4'h0, rw(), 0);
        op(3'h5, 0, 1, rb, 4'h0, '0, 0);
        op(SEL, 0, 1, rb + 17'h1, 4'h0, '0, 0);
        // ==========================================================
        // clock gate holds pending write and burst position
        op(SEL, 0, 0, rb + 17'h2, 4'($urandom), rw(), 0);
        repeat (2) op(3'($urandom), 1'($urandom), 0, rb, 4'($urandom), rw(), 1);
        op(SEL, 0, 1, rb + 17'h2, 4'h0, '0, 0);
        op(SEL, 1, 1, rb, 4'h0, '0, 1);
        op(SEL, 1, 1, rb, 4'h0, '0, 0);
        // ==========================================================
        // output gate floats the bus without a clock edge
        host.og_n = 1'b1;
        #1;
        chk({35'h0, data_oe}, 36'h0, "output gate off");
        host.og_n = 1'b0;
        #1;
        chk({35'h0, data_oe}, 36'h1, "output gate on");
        op(SEL, 1, 1, rb, 4'h0, '0, 0);
        tally_and_finish;
    end
endmodule : zbsp_port_test
